// ==== rtl/pfs_pkg.sv ====
package pfs_pkg;

    // ------------------------------------------------------------
    // clock and timing
    // ------------------------------------------------------------
    localparam int CLK_HZ = 20_000_000;
    localparam int MINUTE_S = 60;
    localparam int CYC_PER_MIN = MINUTE_S * CLK_HZ;

    // ------------------------------------------------------------
    // regulator mode codes and counter limits
    // ------------------------------------------------------------
    localparam logic [1:0] MODE_OFF = 2'h0;
    localparam logic [1:0] MODE_PWM = 2'h1;
    localparam logic [1:0] MODE_ASKIP = 2'h3;
    localparam logic [3:0] CNT_ZERO = 4'h0;
    localparam logic [3:0] CNT_MAX = 4'hF;
    localparam logic [3:0] CNT_ONE = 4'h1;

    // ------------------------------------------------------------
    // failure source bit positions
    // ------------------------------------------------------------
    localparam int FAIL_PU = 0;
    localparam int FAIL_WD = 1;
    localparam int FAIL_REG = 2;
    localparam int FAIL_TSD = 3;

    // ------------------------------------------------------------
    // sequencer states
    // ------------------------------------------------------------
    typedef enum logic [7:0] {
        ST_OFF = 8'h01,
        ST_PWRUP = 8'h02,
        ST_RUN = 8'h04,
        ST_STBY = 8'h08,
        ST_WDRST = 8'h10,
        ST_PWRDN = 8'h20,
        ST_FSTRANS = 8'h40,
        ST_FSLOCK = 8'h80
    } pfs_state_t;

    // fail-safe ok period in minutes from the fuse code
    function automatic logic [5:0] pfs_ok_minutes(input logic [2:0] code);
        case (code)
            3'h0: pfs_ok_minutes = 6'h01;
            3'h1: pfs_ok_minutes = 6'h05;
            3'h2: pfs_ok_minutes = 6'h0A;
            3'h3: pfs_ok_minutes = 6'h0F;
            3'h4: pfs_ok_minutes = 6'h14;
            3'h5: pfs_ok_minutes = 6'h1E;
            3'h6: pfs_ok_minutes = 6'h2D;
            default: pfs_ok_minutes = 6'h3C;
        endcase
    endfunction

endpackage

// ==== rtl/pfs_failsafe_ctrl.sv ====
`timescale 1ns/100ps
// Summary of operation
// - buck in power-up sequence gets PWM standby mode when switching-mode fuse is one
// - buck outside the power-up sequence gets OFF standby mode at power up
// - linear regulator run enable is one only if it is in the sequence
// - standby settings load from the same fused defaults as run settings
// - entering standby with regulators disabled there starts the power-down sequencer
// - each hard watchdog reset increments the watchdog counter up to 15, then compares it
// - counter equal to limit powers down and enters the fail-safe transition
// - counter not equal to limit (below or above it) performs an ordinary hard watchdog reset
// - watchdog pin toggle or internal watchdog event triggers hard reset
// - power-down disables all but always-on supplies in sequence order
// - after power-down: fault goes to fail-safe transition, otherwise low-power off
// - fail-safe transition sets the failure bit matching the cause
// - failure bits hold while supply stays above undervoltage threshold
// - host reads failure bits when on and clears each by writing one
// - fail-safe transition compares then increments fail-safe counter; equal means lockdown
// - bypass fuse one always goes to low-power off instead of lockdown
// - fail-safe limit zero locks down on the first transition
// - fail-safe pin held low in lockdown when its selected fault is present
// - lockdown is left only through a supply power cycle (reset)
// - three-bit fuse selects ok period of 1 to 60 minutes
// - each ok period during system-on decrements fail-safe counter down to zero
// - host may clear the fail-safe counter during system-on states
// - below undervoltage threshold the block is held in reset
module pfs_failsafe_ctrl
    import pfs_pkg::*;
#(
    parameter int NUM_BUCK = 5,
    parameter int NUM_LDO = 2,
    parameter int CYCLES_PER_MIN = CYC_PER_MIN
)
(
    // clock and supply reset
    input wire logic CLK_SYS_I,
    input wire logic RESET_I,
    // fused defaults
    input wire logic DEFAULT_SWITCHING_MODE_FUSE_I,
    input wire logic [NUM_BUCK-1:0] BUCK_IN_SEQ_I,
    input wire logic [NUM_LDO-1:0] LDO_IN_SEQ_I,
    input wire logic FAILSAFE_BYPASS_FUSE_I,
    input wire logic [3:0] FAILSAFE_COUNT_LIMIT_FUSE_I,
    input wire logic [2:0] FAILSAFE_OK_PERIOD_FUSE_I,
    input wire logic [3:0] WATCHDOG_EVENT_LIMIT_I,
    input wire logic [3:0] FAILSAFE_OUTPUT_SEL_I,
    input wire logic STBY_REG_OFF_CFG_I,
    // pins
    input wire logic WATCHDOG_INPUT_PIN_I,
    input wire logic STANDBY_PIN_I,
    // events from neighbouring logic
    input wire logic POWER_ON_I,
    input wire logic TURN_OFF_I,
    input wire logic SEQ_DONE_I,
    input wire logic WD_INT_EVENT_I,
    input wire logic PU_FAULT_I,
    input wire logic REG_FAULT_I,
    input wire logic TSD_FAULT_I,
    // host controls
    input wire logic [3:0] FAIL_CLR_I,
    input wire logic FAILSAFE_EVENT_COUNTER_CLR_I,
    // sequencer commands
    output logic PU_SEQ_START_O,
    output logic PD_SEQ_START_O,
    output logic HARD_WD_RESET_O,
    // regulator defaults
    output logic [2*NUM_BUCK-1:0] BUCK_STANDBY_OPERATING_MODE_O,
    output logic [NUM_LDO-1:0] LINEAR_REG_RUN_ENABLE_O,
    // status
    output logic [7:0] STATE_O,
    output logic SYSTEM_ON_O,
    output logic [3:0] FAIL_FLAGS_O,
    output logic [3:0] FAILSAFE_EVENT_COUNTER_O,
    output logic [3:0] WATCHDOG_EVENT_COUNTER_O,
    // open-drain fail-safe pin
    output logic FAILSAFE_OUTPUT_PIN_O,
    output logic FAILSAFE_OUTPUT_PIN_OE_O
);

    localparam logic [30:0] CYC_MIN_M1 = 31'(CYCLES_PER_MIN - 1);

    // ------------------------------------------------------------
    // registers
    // ------------------------------------------------------------
    pfs_state_t state_reg, state_next;
    logic [3:0] cause_reg, cause_next;
    logic [3:0] fail_reg, fail_next;
    logic [3:0] wd_cnt_reg, wd_cnt_next;
    logic [3:0] failsafe_event_counter_reg, failsafe_event_counter_next;
    logic [30:0] pre_cnt_reg, pre_cnt_next;
    logic [5:0] min_cnt_reg, min_cnt_next;
    logic [2*NUM_BUCK-1:0] buck_mode_reg, buck_mode_next;
    logic [NUM_LDO-1:0] ldo_en_reg, ldo_en_next;
    logic pu_start_reg, pd_start_reg, wd_rst_reg, failsafe_output_pin_reg;
    logic wdi_s1_reg, wdi_s2_reg, wdi_s3_reg, stb_s1_reg, stb_s2_reg;

    // ------------------------------------------------------------
    // decode
    // ------------------------------------------------------------
    wire sys_on = (state_reg == ST_RUN) || (state_reg == ST_STBY);
    wire wdi_toggle = wdi_s2_reg ^ wdi_s3_reg;
    wire wd_event = wdi_toggle | WD_INT_EVENT_I;
    wire [3:0] wd_cnt_inc = (wd_cnt_reg == CNT_MAX) ? CNT_MAX : wd_cnt_reg + CNT_ONE;
    wire wd_max_hit = (wd_cnt_inc == WATCHDOG_EVENT_LIMIT_I);
    wire fs_hit = !FAILSAFE_BYPASS_FUSE_I && (failsafe_event_counter_reg == FAILSAFE_COUNT_LIMIT_FUSE_I);
    wire entering = (state_next != state_reg);
    wire load_dflt = entering && (state_next == ST_PWRUP);
    wire [1:0] pwr_mode = DEFAULT_SWITCHING_MODE_FUSE_I ? MODE_PWM : MODE_ASKIP;
    wire min_wrap = (pre_cnt_reg == CYC_MIN_M1);
    wire ok_tick = min_wrap && (min_cnt_reg == pfs_ok_minutes(FAILSAFE_OK_PERIOD_FUSE_I) - 6'h01);
    wire [3:0] clr_mask = sys_on ? FAIL_CLR_I : 4'h0;
    wire [3:0] set_mask = (state_reg == ST_FSTRANS) ? cause_reg : 4'h0;

    // ------------------------------------------------------------
    // pin synchronisers
    // ------------------------------------------------------------
    always_ff @(posedge CLK_SYS_I or posedge RESET_I)
    begin
        if (RESET_I)
        begin
            wdi_s1_reg <= 1'b0;
            wdi_s2_reg <= 1'b0;
            wdi_s3_reg <= 1'b0;
            stb_s1_reg <= 1'b0;
            stb_s2_reg <= 1'b0;
        end
        else
        begin
            wdi_s1_reg <= WATCHDOG_INPUT_PIN_I;
            wdi_s2_reg <= wdi_s1_reg;
            wdi_s3_reg <= wdi_s2_reg;
            stb_s1_reg <= STANDBY_PIN_I;
            stb_s2_reg <= stb_s1_reg;
        end
    end

    // ------------------------------------------------------------
    // state sequencing
    // ------------------------------------------------------------
    always_comb
    begin
        state_next = state_reg;
        cause_next = cause_reg;
        case (state_reg)
            ST_OFF:
                if (POWER_ON_I)
                    state_next = ST_PWRUP;
            ST_PWRUP:
                if (PU_FAULT_I)
                begin
                    state_next = ST_PWRDN;
                    cause_next = 4'h1 << FAIL_PU;
                end
                else if (SEQ_DONE_I)
                    state_next = ST_RUN;
            ST_RUN, ST_STBY:
                if (TSD_FAULT_I)
                begin
                    state_next = ST_PWRDN;
                    cause_next = 4'h1 << FAIL_TSD;
                end
                else if (REG_FAULT_I)
                begin
                    state_next = ST_PWRDN;
                    cause_next = 4'h1 << FAIL_REG;
                end
                else if (wd_event)
                    state_next = ST_WDRST;
                else if (TURN_OFF_I)
                begin
                    state_next = ST_PWRDN;
                    cause_next = 4'h0;
                end
                else if (stb_s2_reg)
                    state_next = ST_STBY;
                else
                    state_next = ST_RUN;
            ST_WDRST:
                if (wd_max_hit)
                begin
                    state_next = ST_PWRDN;
                    cause_next = 4'h1 << FAIL_WD;
                end
                else
                    state_next = ST_PWRUP;
            ST_PWRDN:
                if (SEQ_DONE_I)
                    state_next = (cause_reg != 4'h0) ? ST_FSTRANS : ST_OFF;
            ST_FSTRANS:
                state_next = fs_hit ? ST_FSLOCK : ST_OFF;
            ST_FSLOCK:
                state_next = ST_FSLOCK;
            default:
                state_next = ST_OFF;
        endcase
    end

    // ------------------------------------------------------------
    // counters, flags and power-up defaults
    // ------------------------------------------------------------
    always_comb
    begin
        wd_cnt_next = (state_reg == ST_WDRST) ? wd_cnt_inc : wd_cnt_reg;
        fail_next = (fail_reg & ~clr_mask) | set_mask;
        failsafe_event_counter_next = failsafe_event_counter_reg;
        pre_cnt_next = pre_cnt_reg;
        min_cnt_next = min_cnt_reg;
        if (state_reg == ST_FSTRANS && failsafe_event_counter_reg != CNT_MAX)
            failsafe_event_counter_next = failsafe_event_counter_reg + CNT_ONE;
        else if (sys_on && FAILSAFE_EVENT_COUNTER_CLR_I)
            failsafe_event_counter_next = CNT_ZERO;
        else if (sys_on && ok_tick && failsafe_event_counter_reg != CNT_ZERO)
            failsafe_event_counter_next = failsafe_event_counter_reg - CNT_ONE;
        if (!sys_on || failsafe_event_counter_reg == CNT_ZERO)
        begin
            pre_cnt_next = 31'h0;
            min_cnt_next = 6'h00;
        end
        else if (min_wrap)
        begin
            pre_cnt_next = 31'h0;
            min_cnt_next = ok_tick ? 6'h00 : min_cnt_reg + 6'h01;
        end
        else
            pre_cnt_next = pre_cnt_reg + 31'h1;
        buck_mode_next = buck_mode_reg;
        ldo_en_next = ldo_en_reg;
        if (load_dflt)
        begin
            for (int i = 0; i < NUM_BUCK; i++)
                buck_mode_next[2*i +: 2] = BUCK_IN_SEQ_I[i] ? pwr_mode : MODE_OFF;
            ldo_en_next = LDO_IN_SEQ_I;
        end
    end

    // ------------------------------------------------------------
    // state and data registers, cleared by the supply reset
    // ------------------------------------------------------------
    always_ff @(posedge CLK_SYS_I or posedge RESET_I)
    begin
        if (RESET_I)
        begin
            state_reg <= ST_OFF;
            cause_reg <= 4'h0;
            fail_reg <= 4'h0;
            wd_cnt_reg <= CNT_ZERO;
            failsafe_event_counter_reg <= CNT_ZERO;
            pre_cnt_reg <= 31'h0;
            min_cnt_reg <= 6'h00;
            buck_mode_reg <= '0;
            ldo_en_reg <= '0;
        end
        else
        begin
            state_reg <= state_next;
            cause_reg <= cause_next;
            fail_reg <= fail_next;
            wd_cnt_reg <= wd_cnt_next;
            failsafe_event_counter_reg <= failsafe_event_counter_next;
            pre_cnt_reg <= pre_cnt_next;
            min_cnt_reg <= min_cnt_next;
            buck_mode_reg <= buck_mode_next;
            ldo_en_reg <= ldo_en_next;
        end
    end

    // ------------------------------------------------------------
    // command pulses and fail-safe pin
    // ------------------------------------------------------------
    always_ff @(posedge CLK_SYS_I or posedge RESET_I)
    begin
        if (RESET_I)
        begin
            pu_start_reg <= 1'b0;
            pd_start_reg <= 1'b0;
            wd_rst_reg <= 1'b0;
            failsafe_output_pin_reg <= 1'b0;
        end
        else
        begin
            pu_start_reg <= load_dflt;
            pd_start_reg <= (entering && state_next == ST_PWRDN)
                || (entering && state_next == ST_STBY && STBY_REG_OFF_CFG_I);
            wd_rst_reg <= (state_reg == ST_WDRST) && !wd_max_hit;
            if (entering && state_next == ST_FSLOCK)
                failsafe_output_pin_reg <= |(FAILSAFE_OUTPUT_SEL_I & cause_reg);
        end
    end

    // ------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------
    assign PU_SEQ_START_O = pu_start_reg;
    assign PD_SEQ_START_O = pd_start_reg;
    assign HARD_WD_RESET_O = wd_rst_reg;
    assign BUCK_STANDBY_OPERATING_MODE_O = buck_mode_reg;
    assign LINEAR_REG_RUN_ENABLE_O = ldo_en_reg;
    assign STATE_O = state_reg;
    assign SYSTEM_ON_O = sys_on;
    assign FAIL_FLAGS_O = fail_reg;
    assign FAILSAFE_EVENT_COUNTER_O = failsafe_event_counter_reg;
    assign WATCHDOG_EVENT_COUNTER_O = wd_cnt_reg;
    assign FAILSAFE_OUTPUT_PIN_O = 1'b0;
    assign FAILSAFE_OUTPUT_PIN_OE_O = failsafe_output_pin_reg;

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    default clocking cb @(posedge CLK_SYS_I); endclocking
    default disable iff (RESET_I);

    ldo_default_a: assert property (load_dflt |=> ldo_en_reg == $past(LDO_IN_SEQ_I))
        else $error("linear regulator default not loaded");
    buck_off_a: assert property (load_dflt && !BUCK_IN_SEQ_I[0] |=> buck_mode_reg[1:0] == MODE_OFF)
        else $error("buck outside sequence not off");
    buck_pwm_a: assert property (load_dflt && BUCK_IN_SEQ_I[0] && DEFAULT_SWITCHING_MODE_FUSE_I
        |=> buck_mode_reg[1:0] == MODE_PWM)
        else $error("buck standby mode not pwm");
    wd_count_a: assert property (state_reg == ST_WDRST && wd_cnt_reg != CNT_MAX
        |=> wd_cnt_reg == $past(wd_cnt_reg) + CNT_ONE)
        else $error("watchdog counter not incremented");
    wd_limit_a: assert property (state_reg == ST_WDRST && wd_max_hit
        |=> state_reg == ST_PWRDN && cause_reg[FAIL_WD] ##0 PD_SEQ_START_O)
        else $error("watchdog limit did not power down");
    wd_reset_a: assert property (state_reg == ST_WDRST && !wd_max_hit
        |=> HARD_WD_RESET_O && state_reg == ST_PWRUP ##0 PU_SEQ_START_O)
        else $error("hard watchdog reset not performed");
    pd_done_a: assert property (state_reg == ST_PWRDN && SEQ_DONE_I && cause_reg == 4'h0
        |=> state_reg == ST_OFF)
        else $error("non-fault power down did not go off");
    fail_set_a: assert property (state_reg == ST_FSTRANS
        |=> (fail_reg & $past(cause_reg)) == $past(cause_reg))
        else $error("failure bit not set");
    fail_hold_a: assert property (!sys_on && state_reg != ST_FSTRANS |=> $stable(fail_reg))
        else $error("failure bits changed while off");
    fail_clr_a: assert property (sys_on && (|FAIL_CLR_I)
        |=> (fail_reg & $past(FAIL_CLR_I)) == 4'h0)
        else $error("failure bit not cleared");
    fs_lock_a: assert property (state_reg == ST_FSTRANS && fs_hit |=> state_reg == ST_FSLOCK [*3])
        else $error("fail-safe lockdown not entered or left");
    fs_bypass_a: assert property (state_reg == ST_FSTRANS && FAILSAFE_BYPASS_FUSE_I
        |=> state_reg == ST_OFF)
        else $error("bypass did not go off");
    fs_clear_a: assert property (sys_on && FAILSAFE_EVENT_COUNTER_CLR_I |=> failsafe_event_counter_reg == CNT_ZERO)
        else $error("fail-safe counter not cleared");

endmodule

// ==== sim/pfs_seq_model.sv ====
`timescale 1ns/100ps
// ------------------------------------------------------------
// power-up and power-down sequencer stand-in
// ------------------------------------------------------------
module pfs_seq_model
(
    // clock and reset
    input wire logic clk_i,
    input wire logic reset_i,
    // sequence start commands and answer delay
    input wire logic pu_start_i,
    input wire logic pd_start_i,
    input wire logic [3:0] delay_i,
    // sequence finished pulse
    output logic done_o
);
    logic [3:0] wait_reg;

    // a new start restarts the wait, done pulses for one cycle when it runs out
    always_ff @(posedge clk_i or posedge reset_i)
    begin
        if (reset_i)
        begin
            wait_reg <= 4'h0;
            done_o <= 1'b0;
        end
        else
        begin
            done_o <= 1'b0;
            if (pu_start_i || pd_start_i)
                wait_reg <= delay_i;
            else if (wait_reg == 4'h1)
            begin
                done_o <= 1'b1;
                wait_reg <= 4'h0;
            end
            else if (wait_reg != 4'h0)
                wait_reg <= wait_reg - 4'h1;
        end
    end
endmodule

// ==== sim/tb_pfs_failsafe_ctrl.sv ====
`timescale 1ns/100ps
module tb_pfs_failsafe_ctrl;
    import pfs_pkg::*;
    // ------------------------------------------------------------
    // stimulus and observed signals
    // ------------------------------------------------------------
    logic clk, rst, sw_fuse, byp, wd_pin, sb_pin, pwr_on, turn_off, done, wd_evt;
    logic pu_flt, reg_flt, tsd_flt, sb_off, cnt_clr, pu_go, pd_go, hwd, sys_on, fs_pin, fs_oe;
    logic [4:0] buck_seq;
    logic [1:0] ldo_seq, ldo_en;
    logic [3:0] fs_lim, wd_lim, fs_sel, fail_clr, dly, flags, failsafe_event_counter, wd_cnt;
    logic [2:0] ok_code;
    logic [9:0] sb_mode;
    logic [7:0] state;
    int err_total = 0;
    int compares = 0;
    int n_hwd = 0;
    int n_pd = 0;

    pfs_failsafe_ctrl #(.NUM_BUCK(5), .NUM_LDO(2), .CYCLES_PER_MIN(4)) i_pfs_failsafe_ctrl (
        .CLK_SYS_I(clk), .RESET_I(rst), .DEFAULT_SWITCHING_MODE_FUSE_I(sw_fuse),
        .BUCK_IN_SEQ_I(buck_seq), .LDO_IN_SEQ_I(ldo_seq), .FAILSAFE_BYPASS_FUSE_I(byp),
        .FAILSAFE_COUNT_LIMIT_FUSE_I(fs_lim), .FAILSAFE_OK_PERIOD_FUSE_I(ok_code),
        .WATCHDOG_EVENT_LIMIT_I(wd_lim), .FAILSAFE_OUTPUT_SEL_I(fs_sel),
        .STBY_REG_OFF_CFG_I(sb_off), .WATCHDOG_INPUT_PIN_I(wd_pin), .STANDBY_PIN_I(sb_pin),
        .POWER_ON_I(pwr_on), .TURN_OFF_I(turn_off), .SEQ_DONE_I(done), .WD_INT_EVENT_I(wd_evt),
        .PU_FAULT_I(pu_flt), .REG_FAULT_I(reg_flt), .TSD_FAULT_I(tsd_flt),
        .FAIL_CLR_I(fail_clr), .FAILSAFE_EVENT_COUNTER_CLR_I(cnt_clr), .PU_SEQ_START_O(pu_go),
        .PD_SEQ_START_O(pd_go), .HARD_WD_RESET_O(hwd), .BUCK_STANDBY_OPERATING_MODE_O(sb_mode),
        .LINEAR_REG_RUN_ENABLE_O(ldo_en), .STATE_O(state), .SYSTEM_ON_O(sys_on),
        .FAIL_FLAGS_O(flags), .FAILSAFE_EVENT_COUNTER_O(failsafe_event_counter),
        .WATCHDOG_EVENT_COUNTER_O(wd_cnt), .FAILSAFE_OUTPUT_PIN_O(fs_pin),
        .FAILSAFE_OUTPUT_PIN_OE_O(fs_oe));

    pfs_seq_model i_pfs_seq_model (.clk_i(clk), .reset_i(rst), .pu_start_i(pu_go),
        .pd_start_i(pd_go), .delay_i(dly), .done_o(done));

    // ------------------------------------------------------------
    // clock, pulse counters and helpers
    // ------------------------------------------------------------
    initial
    begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end

    // count one-cycle command pulses
    always @(posedge clk)
    begin
        if (hwd === 1'b1) n_hwd <= n_hwd + 1;
        if (pd_go === 1'b1) n_pd <= n_pd + 1;
    end

    task automatic chk(input string nm, input logic [9:0] exp, input logic [9:0] got);
        compares++;
        if (got !== exp)
        begin
            err_total++;
            $display("FAIL %s expected %h seen %h", nm, exp, got);
        end
    endtask

    task automatic tick(input int n);
        repeat (n) @(posedge clk);
    endtask

    // bounded wait for a state, sampled at the falling edge
    task automatic wait_st(input logic [7:0] exp);
        int k;
        k = 0;
        @(negedge clk);
        while (state !== exp && k < 200)
        begin
            @(negedge clk);
            k++;
        end
        chk("state", 10'(exp), 10'(state));
    endtask

    task automatic do_reset;
        @(posedge clk);
        rst <= 1'b1;
        tick(5);
        rst <= 1'b0;
        @(negedge clk);
    endtask

    task automatic power_up;
        @(posedge clk);
        pwr_on <= 1'b1;
        wait_st(8'h04);
        @(posedge clk);
        pwr_on <= 1'b0;
    endtask

    task automatic end_sim;
        $display("compares %0d err_total %0d", compares, err_total);
        if (err_total == 0 && compares > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask

    // hang guard
    initial
    begin
        #200000;
        err_total++;
        $display("FAIL run_time expected done seen timeout");
        end_sim();
    end

    // ------------------------------------------------------------
    // test sequence
    // ------------------------------------------------------------
    initial
    begin
        rst = 1'b1; sw_fuse = 1'b1; buck_seq = 5'h15; ldo_seq = 2'h2; byp = 1'b0;
        fs_lim = 4'h2; ok_code = 3'h7; wd_lim = 4'h2; fs_sel = 4'h0; sb_off = 1'b1;
        wd_pin = 1'b0; sb_pin = 1'b0; pwr_on = 1'b0; turn_off = 1'b0; wd_evt = 1'b0;
        pu_flt = 1'b0; reg_flt = 1'b0; tsd_flt = 1'b0; fail_clr = 4'h0; cnt_clr = 1'b0;
        dly = 4'h3;
        tick(5);
        rst <= 1'b0;
        power_up();
        chk("sb_mode", 10'h111, sb_mode);
        chk("ldo_en", 10'h002, 10'(ldo_en));
        chk("sys_on", 10'h001, 10'(sys_on));
        // internal watchdog event below the limit
        @(posedge clk) wd_evt <= 1'b1;
        @(posedge clk) wd_evt <= 1'b0;
        wait_st(8'h10);
        wait_st(8'h04);
        chk("wd_cnt", 10'h001, 10'(wd_cnt));
        chk("n_hwd", 10'h001, 10'(n_hwd));
        // pin toggle reaches the limit
        @(posedge clk) wd_pin <= 1'b1;
        wait_st(8'h20);
        wait_st(8'h01);
        chk("flags", 10'h002, 10'(flags));
        chk("failsafe_event_counter", 10'h001, 10'(failsafe_event_counter));
        chk("n_hwd", 10'h001, 10'(n_hwd));
        chk("n_pd", 10'h001, 10'(n_pd));
        power_up();
        chk("flags", 10'h002, 10'(flags));
        chk("wd_cnt", 10'h002, 10'(wd_cnt));
        @(posedge clk) fail_clr <= 4'h2;
        @(posedge clk) fail_clr <= 4'h0;
        @(negedge clk);
        chk("flags", 10'h000, 10'(flags));
        @(posedge clk) cnt_clr <= 1'b1;
        @(posedge clk) cnt_clr <= 1'b0;
        @(negedge clk);
        chk("failsafe_event_counter", 10'h000, 10'(failsafe_event_counter));
        // thermal fault below the fail-safe limit
        @(posedge clk) tsd_flt <= 1'b1;
        @(posedge clk) tsd_flt <= 1'b0;
        wait_st(8'h01);
        chk("flags", 10'h008, 10'(flags));
        chk("failsafe_event_counter", 10'h001, 10'(failsafe_event_counter));
        // ok timer at 240 cycles
        power_up();
        tick(200);
        chk("failsafe_event_counter", 10'h001, 10'(failsafe_event_counter));
        tick(60);
        chk("failsafe_event_counter", 10'h000, 10'(failsafe_event_counter));
        // ordinary turn-off
        @(posedge clk) turn_off <= 1'b1;
        wait_st(8'h20);
        @(posedge clk) turn_off <= 1'b0;
        wait_st(8'h01);
        chk("flags", 10'h008, 10'(flags));
        chk("n_pd", 10'h003, 10'(n_pd));
        // standby with regulators off
        power_up();
        @(posedge clk) sb_pin <= 1'b1;
        wait_st(8'h08);
        tick(3);
        chk("n_pd", 10'h004, 10'(n_pd));
        @(posedge clk) sb_pin <= 1'b0;
        wait_st(8'h04);
        // regulator fault adds its own failure bit
        @(posedge clk) reg_flt <= 1'b1;
        @(posedge clk) reg_flt <= 1'b0;
        wait_st(8'h01);
        chk("flags", 10'h00C, 10'(flags));
        chk("failsafe_event_counter", 10'h001, 10'(failsafe_event_counter));
        // lockdown on first failure with limit zero
        fs_lim <= 4'h0;
        fs_sel <= 4'h8;
        sw_fuse <= 1'b0;
        do_reset();
        chk("wd_cnt", 10'h000, 10'(wd_cnt));
        chk("flags", 10'h000, 10'(flags));
        power_up();
        chk("sb_mode", 10'h333, sb_mode);
        @(posedge clk) tsd_flt <= 1'b1;
        @(posedge clk) tsd_flt <= 1'b0;
        wait_st(8'h80);
        chk("fs_oe", 10'h001, 10'(fs_oe));
        chk("fs_pin", 10'h000, 10'(fs_pin));
        @(posedge clk) pwr_on <= 1'b1;
        tick(20);
        pwr_on <= 1'b0;
        @(negedge clk);
        chk("state", 10'h080, 10'(state));
        do_reset();
        chk("state", 10'h001, 10'(state));
        chk("fs_oe", 10'h000, 10'(fs_oe));
        // bypass with a power-up failure
        byp <= 1'b1;
        dly <= 4'h8;
        do_reset();
        @(posedge clk) pwr_on <= 1'b1;
        wait_st(8'h02);
        @(posedge clk) pu_flt <= 1'b1;
        pwr_on <= 1'b0;
        @(posedge clk) pu_flt <= 1'b0;
        wait_st(8'h01);
        chk("flags", 10'h001, 10'(flags));
        chk("failsafe_event_counter", 10'h001, 10'(failsafe_event_counter));
        end_sim();
    end
endmodule
